//--- design/slr_pkg.sv
package slr_pkg;
  // Frame kinds on the link
  localparam logic [1:0] FK_XFER_RDY = 2'h0;
  localparam logic [1:0] FK_DATA = 2'h1;
  localparam logic [1:0] FK_RESPONSE = 2'h2;
  // Link outcome codes
  localparam logic [1:0] LO_ACK = 2'h1;
  localparam logic [1:0] LO_NAK = 2'h2;
  localparam logic [1:0] LO_TIMEOUT = 2'h3;
  // Sense codes reported in the response status
  localparam logic [1:0] SC_GOOD = 2'h0;
  localparam logic [1:0] SC_NAK_RECEIVED = 2'h1;
  localparam logic [1:0] SC_ACKNAK_TIMEOUT = 2'h2;
  // Sizes
  localparam int FRAME_W = 8;
  localparam int WIN_DEPTH = 4;
  localparam int IDX_W = 2;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] RETRY_LIMIT_MIN = 3'h1;
  localparam logic [CNT_W-1:0] RETRY_LIMIT_RST = 3'h2;
  // Avalon register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  // Control and status field positions
  localparam int CTRL_RETRIES_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_LIMIT_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_SENSE_LSB = 4;
  localparam int ST_ABORT_BIT = 8;
  localparam int ST_DUP_BIT = 9;

  typedef enum logic [2:0] {
    SLR_IDLE = 3'h0,
    SLR_SEND = 3'h1,
    SLR_WAIT = 3'h3,
    SLR_RESP = 3'h2,
    SLR_RWAIT = 3'h6,
    SLR_END = 3'h7
  } slr_state_t;

  // Clamp a configured retry limit to at least one
  function automatic logic [CNT_W-1:0] slr_limit(input logic [CNT_W-1:0] v);
    return (v < RETRY_LIMIT_MIN) ? RETRY_LIMIT_MIN : v;
  endfunction
endpackage

//--- design/slr_link_if.sv
`timescale 1ns/100ps
interface slr_link_if;
  import slr_pkg::*;
  // Target to initiator frames
  logic t_valid;
  logic [1:0] t_kind;
  logic [FRAME_W-1:0] t_data;
  logic t_retry;
  logic t_cdp;
  logic t_rtx;
  logic [1:0] t_sense;
  logic t_new_conn;
  // Initiator answer to target frame
  logic i_ack_valid;
  logic [1:0] i_ack_code;
  // Initiator to target write frames
  logic i_valid;
  logic [FRAME_W-1:0] i_data;
  logic i_cdp;
  logic i_new_conn;
  // Target answer to initiator frame
  logic t_ack_valid;
  logic [1:0] t_ack_code;

  modport target (
    output t_valid, t_kind, t_data, t_retry, t_cdp, t_rtx, t_sense, t_new_conn,
    input i_ack_valid, i_ack_code,
    input i_valid, i_data, i_cdp, i_new_conn,
    output t_ack_valid, t_ack_code
  );
  modport initiator (
    input t_valid, t_kind, t_data, t_retry, t_cdp, t_rtx, t_sense, t_new_conn,
    output i_ack_valid, i_ack_code,
    output i_valid, i_data, i_cdp, i_new_conn,
    input t_ack_valid, t_ack_code
  );
endinterface

//--- design/slr_retry_ctr.sv
`timescale 1ns/100ps
module slr_retry_ctr
  import slr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic bump,
  input wire logic [CNT_W-1:0] limit,
  // Status
  output logic exhausted
);
  logic [CNT_W-1:0] count_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (bump && !exhausted) begin
      count_q <= count_q + 3'h1;
    end
  end

  // Limit never below one, so every retried DATA or RESPONSE frame gets one resend
  assign exhausted = (count_q >= slr_limit(limit));
endmodule

//--- design/slr_target.sv
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
// Behaviour
// RQ1 - XFER_RDY NAK, no retries: abort, NAK sense
// RQ2 - XFER_RDY timeout, no retries: abort, new connection
// RQ3 - Read recovery chosen by retries setting
// RQ4 - Initiator follows retry bit of XFER_RDY
// RQ5 - Read NAK: resend frames since balance
// RQ6 - Read timeout: resend since balance, new connection
// RQ7 - Write NAK: initiator resends burst
// RQ8 - Write timeout: initiator resends in new connection
// RQ9 - New XFER_RDY or RESPONSE stops write resend
// RQ10 - First resent DATA has pointer bit set
// RQ11 - Every unacked DATA frame resent once minimum
// RQ12 - Read NAK, no retries: abort, NAK sense
// RQ13 - Read timeout, no retries: timeout sense
// RQ14 - Write timeout, no retries: initiator aborts
// RQ15 - Write NAK, no retries: initiator aborts
// RQ16 - RESPONSE NAK: resend with retransmit bit
// RQ17 - RESPONSE timeout: resend in new connection
// RQ18 - Every unacked RESPONSE resent once minimum
// RQ19 - Initiator drops duplicate retransmitted RESPONSE
// RQ20 - Retry bit cleared in XFER_RDY when disabled
// RQ21 - Configurable retry limit, minimum one
module slr_target
  import slr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Received write data
  output logic wr_data_valid,
  output logic [FRAME_W-1:0] wr_data,
  // Link
  slr_link_if.target link
);
  // ==========================================================
  // Registers
  logic retries_q;
  logic [CNT_W-1:0] limit_q;
  logic [FRAME_W-1:0] base_q;
  logic start;
  logic [1:0] sense_q;
  logic done_q;
  slr_state_t state_q;
  logic [31:0] rdata_d;

  assign start = avs_write && !avs_waitrequest && avs_address == REG_CTRL
                 && avs_writedata[CTRL_START_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retries_q <= 1'b0;
      limit_q <= RETRY_LIMIT_RST;
      base_q <= '0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == REG_CTRL) begin
        retries_q <= avs_writedata[CTRL_RETRIES_BIT]; // see RQ3
        limit_q <= avs_writedata[CTRL_LIMIT_LSB +: CNT_W]; // see RQ21
      end else if (avs_address == REG_DATA) begin
        base_q <= avs_writedata[FRAME_W-1:0];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    case (avs_address)
      REG_CTRL: begin
        rdata_d[CTRL_RETRIES_BIT] = retries_q;
        rdata_d[CTRL_LIMIT_LSB +: CNT_W] = limit_q;
      end
      REG_STATUS: begin
        rdata_d[ST_BUSY_BIT] = (state_q != SLR_IDLE);
        rdata_d[ST_DONE_BIT] = done_q;
        rdata_d[ST_SENSE_LSB +: 2] = sense_q;
      end
      REG_DATA: rdata_d[FRAME_W-1:0] = base_q;
      default: rdata_d = 32'h0;
    endcase
  end

  // One wait cycle, answer on the second edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata <= rdata_d;
    end
  end

  // ==========================================================
  // Command sequencer: XFER_RDY, read window, RESPONSE
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] bal_q;
  logic resend_q;
  logic first_rtx_q;
  logic [1:0] kind_q;
  logic ok;
  logic nak;
  logic tmo;
  logic exhausted;
  logic ctr_clear;
  logic ctr_bump;

  assign ok = link.i_ack_valid && link.i_ack_code == LO_ACK;
  assign nak = link.i_ack_valid && link.i_ack_code == LO_NAK;
  assign tmo = link.i_ack_valid && link.i_ack_code == LO_TIMEOUT;
  // Fresh budget for the RESPONSE, even after DATA ran out
  assign ctr_clear = start || (state_q == SLR_WAIT && ok) || (state_q == SLR_RWAIT && ok)
                     || (state_q == SLR_RESP && !resend_q); // see RQ18
  assign ctr_bump = (state_q == SLR_WAIT || state_q == SLR_RWAIT) && (nak || tmo);

  slr_retry_ctr u_ctr (
    .clock(clock),
    .rst_n(rst_n),
    .clear(ctr_clear),
    .bump(ctr_bump),
    .limit(limit_q),
    .exhausted(exhausted)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SLR_IDLE;
      kind_q <= FK_XFER_RDY;
      idx_q <= '0;
      bal_q <= '0;
      sense_q <= SC_GOOD;
      resend_q <= 1'b0;
      first_rtx_q <= 1'b0;
      done_q <= 1'b0;
      link.t_valid <= 1'b0;
      link.t_kind <= FK_XFER_RDY;
      link.t_data <= '0;
      link.t_retry <= 1'b0;
      link.t_cdp <= 1'b0;
      link.t_rtx <= 1'b0;
      link.t_sense <= SC_GOOD;
      link.t_new_conn <= 1'b0;
    end else begin
      link.t_valid <= 1'b0;
      case (state_q)
        SLR_IDLE: begin
          if (start) begin
            state_q <= SLR_SEND;
            kind_q <= FK_XFER_RDY;
            idx_q <= '0;
            bal_q <= '0;
            sense_q <= SC_GOOD;
            resend_q <= 1'b0;
            done_q <= 1'b0;
            link.t_new_conn <= 1'b0;
          end
        end
        SLR_SEND: begin
          link.t_valid <= 1'b1;
          link.t_kind <= kind_q;
          link.t_data <= base_q + FRAME_W'(idx_q);
          link.t_retry <= retries_q; // see RQ20
          link.t_cdp <= first_rtx_q; // see RQ10
          link.t_rtx <= 1'b0;
          first_rtx_q <= 1'b0;
          state_q <= SLR_WAIT;
        end
        SLR_WAIT: begin
          link.t_new_conn <= 1'b0;
          if (ok) begin
            if (kind_q == FK_XFER_RDY) begin
              kind_q <= FK_DATA;
              state_q <= SLR_SEND;
            end else if (idx_q == IDX_W'(WIN_DEPTH - 1)) begin
              state_q <= SLR_RESP;
            end else begin
              idx_q <= idx_q + 2'h1;
              bal_q <= idx_q + 2'h1;
              state_q <= SLR_SEND;
            end
          end else if (nak || tmo) begin
            link.t_new_conn <= tmo; // see RQ2 RQ6 RQ13
            if (kind_q == FK_DATA && retries_q && !exhausted) begin
              idx_q <= bal_q; // see RQ5 RQ6 RQ11
              first_rtx_q <= 1'b1; // see RQ10
              state_q <= SLR_SEND;
            end else begin
              sense_q <= nak ? SC_NAK_RECEIVED : SC_ACKNAK_TIMEOUT; // see RQ1 RQ12 RQ21
              state_q <= SLR_RESP;
            end
          end
        end
        SLR_RESP: begin
          link.t_valid <= 1'b1;
          link.t_kind <= FK_RESPONSE;
          link.t_data <= '0;
          link.t_retry <= 1'b0;
          link.t_cdp <= 1'b0;
          link.t_rtx <= resend_q; // see RQ16 RQ17
          link.t_sense <= sense_q;
          state_q <= SLR_RWAIT;
        end
        SLR_RWAIT: begin
          link.t_new_conn <= 1'b0;
          if (ok) begin
            state_q <= SLR_END;
          end else if (nak || tmo) begin
            link.t_new_conn <= tmo; // see RQ17
            if (!exhausted) begin
              resend_q <= 1'b1; // see RQ18
              state_q <= SLR_RESP;
            end else begin
              state_q <= SLR_END;
            end
          end
        end
        SLR_END: begin
          done_q <= 1'b1;
          state_q <= SLR_IDLE;
        end
        default: state_q <= SLR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Write DATA receive path, every frame acknowledged
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.t_ack_valid <= 1'b0;
      link.t_ack_code <= LO_ACK;
      wr_data_valid <= 1'b0;
      wr_data <= '0;
    end else begin
      link.t_ack_valid <= link.i_valid;
      link.t_ack_code <= LO_ACK;
      wr_data_valid <= link.i_valid;
      if (link.i_valid) begin
        wr_data <= link.i_data;
      end
    end
  end
endmodule

//--- design/slr_initiator.sv
`timescale 1ns/100ps
module slr_initiator
  import slr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write burst control
  input wire logic [FRAME_W-1:0] wr_base,
  input wire logic [CNT_W-1:0] wr_limit,
  // Forces a NAK answer for write frames while waiting
  input wire logic wr_ack_code_force_nak,
  // Results
  output logic resp_valid,
  output logic [1:0] resp_sense,
  output logic resp_dup,
  output logic cmd_abort,
  // Link
  slr_link_if.initiator link
);
  // ==========================================================
  // Acknowledge every target frame
  logic got_resp_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.i_ack_valid <= 1'b0;
      link.i_ack_code <= LO_ACK;
      resp_valid <= 1'b0;
      resp_sense <= SC_GOOD;
      resp_dup <= 1'b0;
      got_resp_q <= 1'b0;
    end else begin
      link.i_ack_valid <= link.t_valid;
      link.i_ack_code <= LO_ACK;
      resp_valid <= 1'b0;
      resp_dup <= 1'b0;
      if (link.t_valid && link.t_kind == FK_XFER_RDY) begin
        got_resp_q <= 1'b0;
      end else if (link.t_valid && link.t_kind == FK_RESPONSE) begin
        if (link.t_rtx && got_resp_q) begin
          resp_dup <= 1'b1; // see RQ19
        end else begin
          resp_valid <= 1'b1;
          resp_sense <= link.t_sense;
          got_resp_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Write burst sender with recovery
  logic retry_q;
  logic active_q;
  logic [IDX_W-1:0] widx_q;
  logic first_q;
  logic wait_q;
  logic nak;
  logic tmo;
  logic ok;
  logic exhausted;

  assign ok = link.t_ack_valid && link.t_ack_code == LO_ACK;
  assign nak = (link.t_ack_valid && link.t_ack_code == LO_NAK) || (wait_q && wr_ack_code_force_nak);
  assign tmo = link.t_ack_valid && link.t_ack_code == LO_TIMEOUT;

  slr_retry_ctr u_ctr (
    .clock(clock),
    .rst_n(rst_n),
    .clear((wait_q && ok) || (link.t_valid && link.t_kind == FK_XFER_RDY)),
    .bump(wait_q && (nak || tmo)),
    .limit(wr_limit),
    .exhausted(exhausted)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_q <= 1'b0;
      active_q <= 1'b0;
      widx_q <= '0;
      first_q <= 1'b0;
      wait_q <= 1'b0;
      cmd_abort <= 1'b0;
      link.i_valid <= 1'b0;
      link.i_data <= '0;
      link.i_cdp <= 1'b0;
      link.i_new_conn <= 1'b0;
    end else begin
      link.i_valid <= 1'b0;
      cmd_abort <= 1'b0;
      if (link.t_valid && link.t_kind != FK_DATA) begin
        // New XFER_RDY restarts, RESPONSE stops resends
        active_q <= (link.t_kind == FK_XFER_RDY); // see RQ9
        retry_q <= link.t_retry; // see RQ4
        widx_q <= '0;
        wait_q <= 1'b0;
        first_q <= 1'b0;
        link.i_new_conn <= 1'b0;
      end else if (active_q && !wait_q) begin
        link.i_valid <= 1'b1;
        link.i_data <= wr_base + FRAME_W'(widx_q);
        link.i_cdp <= first_q; // see RQ10
        first_q <= 1'b0;
        wait_q <= 1'b1;
      end else if (wait_q && ok) begin
        wait_q <= 1'b0;
        link.i_new_conn <= 1'b0;
        if (widx_q == IDX_W'(WIN_DEPTH - 1)) begin
          active_q <= 1'b0;
        end else begin
          widx_q <= widx_q + 2'h1;
        end
      end else if (wait_q && (nak || tmo)) begin
        wait_q <= 1'b0;
        link.i_new_conn <= tmo; // see RQ8
        if (retry_q && !exhausted) begin
          widx_q <= '0; // see RQ7 RQ11
          first_q <= 1'b1;
        end else begin
          active_q <= 1'b0;
          cmd_abort <= 1'b1; // see RQ14 RQ15 RQ21
        end
      end
    end
  end
endmodule

//--- tb/slr_link_properties.sv
`timescale 1ns/100ps
module slr_link_properties
  import slr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link
  input wire logic t_valid,
  input wire logic [1:0] t_kind,
  input wire logic [FRAME_W-1:0] t_data,
  input wire logic t_retry,
  input wire logic t_cdp,
  input wire logic t_rtx,
  input wire logic [1:0] t_sense,
  input wire logic t_new_conn,
  input wire logic i_ack_valid,
  input wire logic [1:0] i_ack_code
);
  // ====================
  // Last frame and its answer
  logic [1:0] kind_q;
  logic [FRAME_W-1:0] data_q;
  logic ret_q, err_q, to_q;
  logic [1:0] sense_q;
  wire bad = i_ack_valid && i_ack_code != LO_ACK;
  wire derr = err_q && kind_q == FK_DATA;
  wire rerr = err_q && kind_q == FK_RESPONSE;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= FK_XFER_RDY;
      data_q <= '0;
      err_q <= 1'b0;
      to_q <= 1'b0;
    end else if (t_valid) begin
      kind_q <= t_kind;
      data_q <= t_data;
      err_q <= 1'b0;
      to_q <= 1'b0;
    end else if (bad) begin
      err_q <= 1'b1;
      to_q <= i_ack_code == LO_TIMEOUT;
    end
  end
  // Expected sense of a command run without retries
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ret_q <= 1'b0;
      sense_q <= SC_GOOD;
    end else if (t_valid && t_kind == FK_XFER_RDY) begin
      ret_q <= t_retry;
      sense_q <= SC_GOOD;
    end else if (bad && !ret_q && kind_q != FK_RESPONSE) begin
      sense_q <= (i_ack_code == LO_TIMEOUT) ? SC_ACKNAK_TIMEOUT : SC_NAK_RECEIVED;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_cdp_first: assert property (
    t_valid && t_kind == FK_DATA |-> t_cdp == derr) else $error("bad pointer bit");
  chk_resend_same: assert property (
    t_valid && t_kind == FK_DATA && derr |-> t_data == data_q) else $error("bad resend");
  chk_timeout_conn: assert property (
    t_valid && to_q |-> t_new_conn) else $error("no new connection");
  chk_resp_rtx: assert property (
    t_valid && t_kind == FK_RESPONSE |-> t_rtx == rerr) else $error("bad retransmit bit");
  chk_rtx_kind: assert property (
    t_valid && t_rtx |-> t_kind == FK_RESPONSE) else $error("retransmit on non response");
  chk_abort_resp: assert property (
    t_valid && err_q && !ret_q && !rerr |-> t_kind == FK_RESPONSE) else $error("no abort");
  chk_resp_sense: assert property (
    t_valid && t_kind == FK_RESPONSE && !ret_q |-> t_sense == sense_q) else $error("bad sense");
  chk_retry_mode: assert property (
    t_valid && t_kind == FK_DATA && derr |-> ret_q) else $error("resend without retries");
  cover property (t_valid && t_cdp);
  cover property (t_valid && t_rtx);
  cover property (i_ack_valid && i_ack_code == LO_TIMEOUT);
endmodule

//--- tb/test_ssp_link_error_recovery.sv
`timescale 1ns/100ps
module test_ssp_link_error_recovery
  import slr_pkg::*;
();
  logic clock, rst_n, fnak, wv, resp_v, abrt, got_a, got_c, wb, dup, got_d;
  logic [3:0] adr [2];
  logic rd [2];
  logic wr [2];
  logic [31:0] wd [2];
  wire [31:0] rq [2];
  wire wq [2];
  logic [FRAME_W-1:0] wbase, wdat;
  logic [CNT_W-1:0] wlim;
  logic [1:0] resp_s, got_s;
  logic [1:0] cq [16];
  logic [15:0] lg [16];
  logic [3:0] fn;
  int wn, wl, err_count, checks;
  // ====================
  // Design ends
  slr_link_if link ();
  slr_link_if link2 ();
  slr_target u_slr_target (.clock(clock), .rst_n(rst_n), .avs_address(adr[0]),
    .avs_read(rd[0]), .avs_write(wr[0]), .avs_writedata(wd[0]), .avs_readdata(rq[0]),
    .avs_waitrequest(wq[0]), .wr_data_valid(wv), .wr_data(wdat), .link(link));
  slr_initiator u_slr_initiator (.clock(clock), .rst_n(rst_n), .wr_base(wbase),
    .wr_limit(wlim), .wr_ack_code_force_nak(fnak), .resp_valid(resp_v), .resp_sense(resp_s),
    .resp_dup(dup), .cmd_abort(abrt), .link(link));
  slr_target u_slr_target_2 (.clock(clock), .rst_n(rst_n), .avs_address(adr[1]),
    .avs_read(rd[1]), .avs_write(wr[1]), .avs_writedata(wd[1]), .avs_readdata(rq[1]),
    .avs_waitrequest(wq[1]), .wr_data_valid(), .wr_data(), .link(link2));
  // Watches the link where NAK and timeout answers are injected
  slr_link_properties u_slr_link_properties (.clock(clock), .rst_n(rst_n),
    .t_valid(link2.t_valid), .t_kind(link2.t_kind), .t_data(link2.t_data),
    .t_retry(link2.t_retry), .t_cdp(link2.t_cdp), .t_rtx(link2.t_rtx),
    .t_sense(link2.t_sense), .t_new_conn(link2.t_new_conn),
    .i_ack_valid(link2.i_ack_valid), .i_ack_code(link2.i_ack_code));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ====================
  // Monitors and scripted far end
  always @(posedge clock) begin
    if (resp_v === 1'b1) got_s <= resp_s;
    if (abrt === 1'b1) got_a <= 1'b1;
    if (dup === 1'b1) got_d <= 1'b1;
    if (wv === 1'b1) begin
      chk("wr_data", wdat, wbase + wn[7:0]);
      wn <= wn + 1;
    end
    // A resent burst starts again at its first frame
    if (link.i_valid === 1'b1 && link.i_cdp === 1'b1) begin
      got_c <= 1'b1;
      wn <= 0;
    end
  end
  always @(posedge clock) begin
    link2.i_ack_valid <= 1'b0;
    link2.i_valid <= 1'b0;
    if (link2.t_valid === 1'b1) begin
      link2.i_ack_valid <= 1'b1;
      link2.i_ack_code <= cq[fn];
      lg[fn] <= {link2.t_kind, link2.t_data, link2.t_cdp, link2.t_rtx, link2.t_retry,
        link2.t_new_conn, link2.t_sense};
      fn <= fn + 4'h1;
      if (link2.t_kind === FK_XFER_RDY && cq[fn] === LO_ACK) wl <= 4;
    end
    if (wl > 0 && wb === 1'b0) begin
      link2.i_valid <= 1'b1;
      link2.i_data <= 8'h50 + wl[7:0];
      wb <= 1'b1;
    end
    if (link2.t_ack_valid === 1'b1) begin
      wb <= 1'b0;
      wl <= wl - 1;
    end
  end
  // ====================
  // Tasks
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tmo();
    err_count++;
    print_verdict();
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task av(input int k, input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clock);
    adr[k] <= a;
    wr[k] <= w;
    rd[k] <= !w;
    wd[k] <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n == 100) tmo();
    end while (wq[k] !== 1'b0);
    q = rq[k];
    rd[k] <= 1'b0;
    wr[k] <= 1'b0;
  endtask
  task wdone(input int k, output logic [31:0] q);
    int n;
    n = 0;
    q = '0;
    while (q[ST_DONE_BIT] !== 1'b1) begin
      if (n == 200) tmo();
      av(k, 1'b0, REG_STATUS, 32'h0, q);
      n++;
    end
  endtask
  task rst();
    rst_n <= 1'b0;
    wl <= 0;
    wb <= 1'b0;
    fn <= 4'h0;
    wn <= 0;
    got_a <= 1'b0;
    got_c <= 1'b0;
    got_d <= 1'b0;
    got_s <= 2'h3;
    foreach (cq[i]) cq[i] = LO_ACK;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  task run2(input logic r, input logic [2:0] lim, input int e, input logic [1:0] c,
    input int e2, input logic [1:0] c2, input int e3, output logic [31:0] q);
    rst();
    cq[e] = c;
    cq[e2] = c2;
    cq[e3] = c2;
    av(1, 1'b1, REG_DATA, 32'h20, q);
    av(1, 1'b1, REG_CTRL, {25'h0, lim, 2'h0, 1'b1, r}, q);
    wdone(1, q);
  endtask
  task s_clean();
    logic [31:0] q;
    rst();
    wbase <= 8'h60;
    av(0, 1'b0, REG_CTRL, 32'h0, q);
    chk("limit_rst", q[6:4], RETRY_LIMIT_RST);
    av(0, 1'b0, 4'hc, 32'h0, q);
    chk("unmapped", q, 32'h0);
    av(0, 1'b1, REG_DATA, 32'h30, q);
    av(0, 1'b1, REG_CTRL, {25'h0, 3'h2, 2'h0, 1'b1, 1'b1}, q);
    wdone(0, q);
    chk("sense", q[5:4], SC_GOOD);
    chk("resp", got_s, SC_GOOD);
    chk("resp_dup", got_d, 1'b0);
    chk("wr_count", wn, 4);
    $display("test clean done");
  endtask
  task s_wr(input logic r);
    logic [31:0] q;
    int n;
    rst();
    fnak <= 1'b1;
    wlim <= 3'h1;
    av(0, 1'b1, REG_CTRL, {25'h0, 3'h2, 2'h0, 1'b1, r}, q);
    n = 0;
    while (got_a !== 1'b1) begin
      if (n == 500) tmo();
      @(posedge clock);
      n++;
    end
    chk("wr_abort", got_a, 1'b1);
    chk("wr_cdp", got_c, r);
    fnak <= 1'b0;
    $display("test write_nak done");
  endtask
  task s_link2();
    logic [31:0] q;
    run2(1'b0, 3'h2, 0, LO_NAK, 0, LO_NAK, 0, q);
    chk("x_retry", lg[0][3], 1'b0);
    chk("x_kind", lg[1][15:14], FK_RESPONSE);
    chk("x_sense", q[5:4], SC_NAK_RECEIVED);
    run2(1'b0, 3'h2, 2, LO_TIMEOUT, 2, LO_TIMEOUT, 2, q);
    chk("to_sense", lg[3][1:0], SC_ACKNAK_TIMEOUT);
    chk("to_conn", lg[3][2], 1'b1);
    run2(1'b1, 3'h2, 2, LO_TIMEOUT, 2, LO_TIMEOUT, 2, q);
    chk("r_retry", lg[0][3], 1'b1);
    chk("r_data", lg[3][13:5], {8'h21, 1'b1});
    chk("r_conn", lg[3][2], 1'b1);
    chk("r_next", lg[4][13:5], {8'h22, 1'b0});
    chk("r_sense", q[5:4], SC_GOOD);
    run2(1'b1, 3'h2, 5, LO_NAK, 6, LO_TIMEOUT, 6, q);
    chk("p_first", lg[5][4], 1'b0);
    chk("p_nak", lg[6][15:14], FK_RESPONSE);
    chk("p_rtx", {lg[6][4], lg[7][4], lg[7][2]}, 3'h7);
    run2(1'b1, 3'h1, 1, LO_NAK, 2, LO_NAK, 3, q);
    chk("l_resend", lg[2][13:5], {8'h20, 1'b1});
    chk("l_kind", lg[3][15:14], FK_RESPONSE);
    chk("l_sense", lg[3][1:0], SC_NAK_RECEIVED);
    chk("l_rtx", {lg[4][15:14], lg[4][4]}, {FK_RESPONSE, 1'b1});
    $display("test read_recovery done");
  endtask
  initial begin
    rst_n = 1'b0;
    adr = '{4'h0, 4'h0};
    rd = '{1'b0, 1'b0};
    wr = '{1'b0, 1'b0};
    wd = '{32'h0, 32'h0};
    wbase = 8'h0;
    wlim = 3'h2;
    fnak = 1'b0;
    link2.i_ack_valid = 1'b0;
    link2.i_ack_code = LO_ACK;
    link2.i_valid = 1'b0;
    link2.i_data = 8'h0;
    link2.i_cdp = 1'b0;
    link2.i_new_conn = 1'b0;
    err_count = 0;
    checks = 0;
    s_clean();
    s_wr(1'b0);
    s_wr(1'b1);
    s_link2();
    print_verdict();
  end
endmodule
